// [hw/cvr_crtc_vert.sv]
// Vertical timing, cursor and display address registers of the CRT controller
`timescale 1ns/1ps

// Contract
// - Cursor starts at start line; off bit hides
// - Cursor ends at end plus one; skew delays
// - Start above end means no cursor
// - Start address from high and low bytes
// - Legacy modes wrap at 16/32/64 KB
// - Cursor where address equals cursor location
// - Pen latches load at line compare, gated reads
// - Vsync starts at 10-bit start line
// - Vsync ends on low four line bits
// - Interrupt clear and enable, both active low
// - Three or five refresh cycles per line
// - Protect bit blocks horizontal group writes; overflow line compare bit 8 stays writable
// - Display ends after end value plus one
// - Next row start adds K times pitch
// - Underline on programmed line plus one
// - Vblank starts at 10-bit start line
// - Vblank ends on low eight line bits
// - Row scan bits replace address bits 13,14
// - Vertical clock optionally halved
// - Address counter steps every 1/2/4 ticks
// - Byte, word or double word addressing
// - Hardware reset bit forces syncs inactive
// - Line compare clears the address counter
module cvr_crtc_vert (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Host indexed port: sel 0 index, 1 data
	input wire logic port_sel_in,
	input wire logic port_wr_in,
	input wire logic port_rd_in,
	input wire logic [7:0] port_wdata_in,
	output logic [7:0] port_rdata_out,
	output logic port_rvalid_out,
	// Horizontal group write pass-through
	output logic hgroup_wr_out,
	output logic [5:0] hgroup_idx_out,
	output logic [7:0] hgroup_wmask_out,
	// Neighbouring configuration
	input wire cvr_pkg::cvr_vert_cfg_t vert_cfg_in,
	input wire logic vsync_readback_select_in,
	input wire logic extension_group0_protect_in,
	input wire logic mono_emulation_in,
	input wire cvr_pkg::cvr_emu_t emulation_in,
	// Timing events
	input wire logic character_clock_tick_in,
	input wire logic hline_tick_in,
	input wire logic hsync_raw_in,
	// Video and memory outputs
	output cvr_pkg::cvr_video_t video_out,
	output logic irq_out,
	output logic [15:0] mem_addr_out,
	output logic [2:0] refresh_cycles_out
);
	import cvr_pkg::*;

	logic [5:0] index_ff;
	logic [7:0] regs_ff [CVR_IDX_CUR_START:CVR_IDX_MODE_CTRL];
	logic [15:0] penlatch_ff;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic hgroup_wr_ff;
	logic [5:0] hgroup_idx_ff;
	logic [7:0] hgroup_wmask_ff;
	logic [9:0] line_ff;
	logic [4:0] row_ff;
	logic half_ff;
	logic [15:0] row_start_ff;
	logic [15:0] ma_ff;
	logic [1:0] div_ff;
	logic vsync_ff;
	logic vblank_ff;
	logic vdisp_ff;
	logic irq_ff;
	logic [3:0] cur_pipe_ff;
	logic cursor_ff;
	logic underline_ff;
	logic hsync_ff;
	logic [15:0] mem_addr_ff;

	logic data_wr;
	logic in_block;
	logic protect_h;
	logic vclk_tick;
	logic frame_wrap;
	logic line_cmp_hit;
	logic row_end;
	logic ma_step;
	logic [15:0] start_addr;
	logic [15:0] cur_addr;
	logic [15:0] wrap_mask;
	logic [15:0] pitch_bytes;
	logic [15:0] nxt_row_start;
	logic [9:0] vss;
	logic [9:0] vbs;
	logic [10:0] vde_plus1;
	logic [5:0] cur_last;
	logic cur_raw;
	logic pen_visible;
	logic [7:0] nxt_rdata;
	logic [15:0] nxt_mem_addr;
	cvr_addr_mode_t addr_mode;
	logic sync_run;

	// Field views of the stored registers
	assign start_addr = {regs_ff[CVR_IDX_START_HI], regs_ff[CVR_IDX_START_LO]};
	assign cur_addr = {regs_ff[CVR_IDX_CURLOC_HI], regs_ff[CVR_IDX_CURLOC_LO]};
	assign vss = {vert_cfg_in.vsync_start_hi, regs_ff[CVR_IDX_VSYNC_START]};
	assign vbs = {vert_cfg_in.vblank_start_hi, regs_ff[CVR_IDX_VBLANK_START]};
	assign vde_plus1 = {1'b0, vert_cfg_in.vdisp_end_hi, regs_ff[CVR_IDX_VDISP_END]} + 11'h001;
	assign cur_last = {1'b0, regs_ff[CVR_IDX_CUR_END][4:0]} + 6'h01;
	assign pen_visible = mono_emulation_in | ~vsync_readback_select_in;
	assign protect_h = regs_ff[CVR_IDX_VSYNC_END][CVR_BIT_GROUP0_PROTECT] | extension_group0_protect_in;
	assign sync_run = regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_HW_RESET_N];

	// Legacy emulation wrap of start and cursor addresses
	always_comb begin
		unique case (emulation_in)
			CVR_EMU_16K: wrap_mask = CVR_WRAP_16K;
			CVR_EMU_32K: wrap_mask = CVR_WRAP_32K;
			CVR_EMU_64K: wrap_mask = CVR_WRAP_64K;
			CVR_EMU_NONE: wrap_mask = CVR_WRAP_64K;
		endcase
	end

	// Addressing mode from double word and byte/word bits
	always_comb begin
		if (regs_ff[CVR_IDX_UNDERLINE][CVR_BIT_DOUBLE_WORD]) begin
			addr_mode = CVR_ADDR_DWORD;
		end else if (regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_BYTE_WORD]) begin
			addr_mode = CVR_ADDR_BYTE;
		end else begin
			addr_mode = CVR_ADDR_WORD;
		end
	end

	// Pitch in bytes: K is 2 byte, 4 word, 8 double word
	always_comb begin
		unique case (addr_mode)
			CVR_ADDR_BYTE: pitch_bytes = {7'h00, regs_ff[CVR_IDX_ROW_PITCH], 1'b0};
			CVR_ADDR_WORD: pitch_bytes = {6'h00, regs_ff[CVR_IDX_ROW_PITCH], 2'h0};
			default: pitch_bytes = {5'h00, regs_ff[CVR_IDX_ROW_PITCH], 3'h0};
		endcase
	end
	assign nxt_row_start = row_start_ff + pitch_bytes;

	// Host port: index and data registers
	assign data_wr = port_wr_in & port_sel_in;
	assign in_block = (index_ff >= CVR_IDX_CUR_START) && (index_ff <= CVR_IDX_MODE_CTRL);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			index_ff <= 6'h00;
		end else if (port_wr_in && !port_sel_in) begin
			index_ff <= port_wdata_in[5:0];
		end
	end

	// Register storage, reserved bits forced to zero
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = CVR_IDX_CUR_START; i <= CVR_IDX_MODE_CTRL; i++) begin
				regs_ff[i] <= CVR_REG_RESET;
			end
		end else if (data_wr && in_block) begin
			unique case (index_ff)
				CVR_IDX_CUR_START: regs_ff[index_ff] <= port_wdata_in & CVR_MASK_CUR_START;
				CVR_IDX_CUR_END: regs_ff[index_ff] <= port_wdata_in & CVR_MASK_CUR_END;
				CVR_IDX_UNDERLINE: regs_ff[index_ff] <= port_wdata_in & CVR_MASK_UNDERLINE;
				CVR_IDX_MODE_CTRL: regs_ff[index_ff] <= port_wdata_in & CVR_MASK_MODE_CTRL;
				default: regs_ff[index_ff] <= port_wdata_in;
			endcase
		end
	end

	// Horizontal group write strobe with protection mask
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hgroup_wr_ff <= 1'b0;
			hgroup_idx_ff <= 6'h00;
			hgroup_wmask_ff <= 8'h00;
		end else begin
			hgroup_wr_ff <= data_wr && (index_ff <= CVR_IDX_HGROUP_LAST);
			hgroup_idx_ff <= index_ff;
			if (!protect_h) begin
				hgroup_wmask_ff <= 8'hff;
			end else if (index_ff == CVR_IDX_OVERFLOW) begin
				hgroup_wmask_ff <= 8'h01 << CVR_BIT_LINE_CMP8;
			end else begin
				hgroup_wmask_ff <= 8'h00;
			end
		end
	end

	// Read data mux, pen latches shadow the vertical sync pair
	always_comb begin
		nxt_rdata = 8'h00;
		if (!port_sel_in) begin
			nxt_rdata = {2'h0, index_ff};
		end else if (in_block) begin
			if (pen_visible && index_ff == CVR_IDX_VSYNC_START) begin
				nxt_rdata = penlatch_ff[15:8];
			end else if (pen_visible && index_ff == CVR_IDX_VSYNC_END) begin
				nxt_rdata = penlatch_ff[7:0];
			end else begin
				nxt_rdata = regs_ff[index_ff];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= port_rd_in;
			if (port_rd_in) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// Vertical clock: every line, or every second line
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			half_ff <= 1'b0;
		end else if (hline_tick_in) begin
			half_ff <= ~half_ff;
		end
	end
	assign vclk_tick = hline_tick_in & (~regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_VCLK_HALF] | half_ff);

	// Line and row scan counters
	assign frame_wrap = ({1'b0, line_ff} == ({1'b0, vert_cfg_in.vert_total} + 11'h001));
	assign line_cmp_hit = (line_ff == vert_cfg_in.line_compare);
	assign row_end = (row_ff == vert_cfg_in.max_scan);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			line_ff <= 10'h000;
			row_ff <= 5'h00;
		end else if (vclk_tick) begin
			line_ff <= frame_wrap ? 10'h000 : line_ff + 10'h001;
			row_ff <= (frame_wrap || row_end) ? 5'h00 : row_ff + 5'h01;
		end
	end

	// Address counter step divider
	always_comb begin
		unique case ({regs_ff[CVR_IDX_UNDERLINE][CVR_BIT_COUNT_BY_FOUR],
			regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_COUNT_BY_TWO]})
			2'b00: ma_step = character_clock_tick_in;
			2'b10: ma_step = character_clock_tick_in && (div_ff == 2'h3);
			default: ma_step = character_clock_tick_in && div_ff[0];
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			div_ff <= 2'h0;
		end else if (hline_tick_in) begin
			div_ff <= 2'h0;
		end else if (character_clock_tick_in) begin
			div_ff <= div_ff + 2'h1;
		end
	end

	// Row start and display address counter
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			row_start_ff <= 16'h0000;
			ma_ff <= 16'h0000;
		end else if (vclk_tick) begin
			if (frame_wrap) begin
				row_start_ff <= start_addr & wrap_mask;
				ma_ff <= start_addr & wrap_mask;
			end else if (line_cmp_hit) begin
				row_start_ff <= 16'h0000;
				ma_ff <= 16'h0000;
			end else if (row_end) begin
				row_start_ff <= nxt_row_start;
				ma_ff <= nxt_row_start;
			end else begin
				ma_ff <= row_start_ff;
			end
		end else if (hline_tick_in) begin
			ma_ff <= row_start_ff;
		end else if (ma_step) begin
			ma_ff <= ma_ff + 16'h0001;
		end
	end

	// Pen latches capture the counter at line compare
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			penlatch_ff <= 16'h0000;
		end else if (vclk_tick && line_cmp_hit) begin
			penlatch_ff <= ma_ff;
		end
	end

	// Logical to physical address translation
	always_comb begin
		unique case (addr_mode)
			CVR_ADDR_BYTE: nxt_mem_addr = ma_ff;
			CVR_ADDR_WORD: nxt_mem_addr = {ma_ff[14:0], regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_WORD_WRAP] ?
				ma_ff[15] : ma_ff[13]};
			default: nxt_mem_addr = {ma_ff[13:0], ma_ff[13], ma_ff[12]};
		endcase
		if (vdisp_ff && !regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_ROWSCAN_A13_N]) begin
			nxt_mem_addr[13] = row_ff[0];
		end
		if (vdisp_ff && !regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_ROWSCAN_A14_N]) begin
			nxt_mem_addr[14] = row_ff[1];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mem_addr_ff <= 16'h0000;
		end else begin
			mem_addr_ff <= nxt_mem_addr;
		end
	end

	// Vertical sync: set wins when start and end coincide
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			vsync_ff <= 1'b0;
		end else if (line_ff == vss) begin
			vsync_ff <= 1'b1;
		end else if (line_ff[3:0] == regs_ff[CVR_IDX_VSYNC_END][3:0]) begin
			vsync_ff <= 1'b0;
		end
	end

	// Vertical blank window
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			vblank_ff <= 1'b0;
		end else if (line_ff == vbs) begin
			vblank_ff <= 1'b1;
		end else if (line_ff[7:0] == regs_ff[CVR_IDX_VBLANK_END]) begin
			vblank_ff <= 1'b0;
		end
	end

	// Vertical active display from line 0 to end value plus one
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			vdisp_ff <= 1'b0;
		end else if ({1'b0, line_ff} == vde_plus1) begin
			vdisp_ff <= 1'b0;
		end else if (line_ff == 10'h000) begin
			vdisp_ff <= 1'b1;
		end
	end

	// Vertical interrupt raised at end of display
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_ff <= 1'b0;
		end else if (!regs_ff[CVR_IDX_VSYNC_END][CVR_BIT_VINT_CLEAR]) begin
			irq_ff <= 1'b0;
		end else if (vdisp_ff && ({1'b0, line_ff} == vde_plus1)
			&& !regs_ff[CVR_IDX_VSYNC_END][CVR_BIT_VINT_ENABLE_N]) begin
			irq_ff <= 1'b1;
		end
	end

	// Cursor match, line window and skew pipeline
	assign cur_raw = vdisp_ff
		&& ((ma_ff & wrap_mask) == (cur_addr & wrap_mask))
		&& !regs_ff[CVR_IDX_CUR_START][CVR_BIT_CURSOR_OFF]
		&& (regs_ff[CVR_IDX_CUR_START][4:0] <= regs_ff[CVR_IDX_CUR_END][4:0])
		&& (row_ff >= regs_ff[CVR_IDX_CUR_START][4:0])
		&& ({1'b0, row_ff} <= cur_last);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cur_pipe_ff <= 4'h0;
		end else if (character_clock_tick_in) begin
			cur_pipe_ff <= {cur_pipe_ff[2:0], cur_raw};
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cursor_ff <= 1'b0;
		end else if (character_clock_tick_in) begin
			unique case (regs_ff[CVR_IDX_CUR_END][6:5])
				2'h0: cursor_ff <= cur_raw;
				2'h1: cursor_ff <= cur_pipe_ff[0];
				2'h2: cursor_ff <= cur_pipe_ff[1];
				2'h3: cursor_ff <= cur_pipe_ff[2];
			endcase
		end
	end

	// Underline line and horizontal sync gate
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			underline_ff <= 1'b0;
			hsync_ff <= 1'b0;
		end else begin
			underline_ff <= vdisp_ff && ({1'b0, row_ff} == ({1'b0, regs_ff[CVR_IDX_UNDERLINE][4:0]} + 6'h01));
			hsync_ff <= hsync_raw_in && regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_HW_RESET_N];
		end
	end

	// Output drive
	assign port_rdata_out = rdata_ff;
	assign port_rvalid_out = rvalid_ff;
	assign hgroup_wr_out = hgroup_wr_ff;
	assign hgroup_idx_out = hgroup_idx_ff;
	assign hgroup_wmask_out = hgroup_wmask_ff;
	assign video_out.hsync = hsync_ff;
	assign video_out.vsync = vsync_ff && regs_ff[CVR_IDX_MODE_CTRL][CVR_BIT_HW_RESET_N];
	assign video_out.vblank = vblank_ff;
	assign video_out.vdisplay = vdisp_ff;
	assign video_out.cursor = cursor_ff;
	assign video_out.underline = underline_ff;
	assign irq_out = irq_ff;
	assign mem_addr_out = mem_addr_ff;
	assign refresh_cycles_out = regs_ff[CVR_IDX_VSYNC_END][CVR_BIT_REFRESH_FIVE] ?
		CVR_REFRESH_FIVE : CVR_REFRESH_THREE;

	// Checks
	AST_SYNC_GATED: assert property (@(posedge clk_in) disable iff (reset_in)
		!sync_run |-> !video_out.vsync)
		else $error("vsync active while hardware reset bit low");
	AST_HSYNC_GATED: assert property (@(posedge clk_in) disable iff (reset_in)
		!$past(sync_run) |-> !video_out.hsync)
		else $error("hsync active while hardware reset bit low");
	AST_CURSOR_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
		regs_ff[CVR_IDX_CUR_START][CVR_BIT_CURSOR_OFF] |-> !cur_raw)
		else $error("cursor raised while cursor off");
	AST_CURSOR_ORDER: assert property (@(posedge clk_in) disable iff (reset_in)
		(regs_ff[CVR_IDX_CUR_START][4:0] > regs_ff[CVR_IDX_CUR_END][4:0]) |-> !cur_raw)
		else $error("cursor raised with start above end");
	AST_IRQ_CLEAR: assert property (@(posedge clk_in) disable iff (reset_in)
		!regs_ff[CVR_IDX_VSYNC_END][CVR_BIT_VINT_CLEAR] |=> !irq_out)
		else $error("interrupt not cleared by clear bit");
	AST_IRQ_DISABLED: assert property (@(posedge clk_in) disable iff (reset_in)
		(!irq_out && regs_ff[CVR_IDX_VSYNC_END][CVR_BIT_VINT_ENABLE_N]) |=> !irq_out)
		else $error("interrupt raised while disabled");
	AST_REFRESH: assert property (@(posedge clk_in) disable iff (reset_in)
		refresh_cycles_out == (regs_ff[CVR_IDX_VSYNC_END][6] ? 3'h5 : 3'h3))
		else $error("wrong refresh cycle count");
	AST_LINE_CMP: assert property (@(posedge clk_in) disable iff (reset_in)
		(vclk_tick && line_cmp_hit && !frame_wrap) |=> (ma_ff == 16'h0000) && (penlatch_ff == $past(ma_ff)))
		else $error("line compare did not clear counter or load pen latch");
	AST_PROTECT: assert property (@(posedge clk_in) disable iff (reset_in)
		(protect_h && index_ff != CVR_IDX_OVERFLOW) |=> (hgroup_wmask_out == 8'h00))
		else $error("horizontal group write not blocked");
	AST_VDISP_END: assert property (@(posedge clk_in) disable iff (reset_in)
		({1'b0, line_ff} == vde_plus1) |=> !video_out.vdisplay)
		else $error("display did not end at end value plus one");
endmodule

// [hw/cvr_pkg.sv]
// Shared constants and carrier types for the vertical CRT timing register block
package cvr_pkg;
	// Register indices
	localparam logic [5:0] CVR_IDX_CUR_START = 6'h0a;
	localparam logic [5:0] CVR_IDX_CUR_END = 6'h0b;
	localparam logic [5:0] CVR_IDX_START_HI = 6'h0c;
	localparam logic [5:0] CVR_IDX_START_LO = 6'h0d;
	localparam logic [5:0] CVR_IDX_CURLOC_HI = 6'h0e;
	localparam logic [5:0] CVR_IDX_CURLOC_LO = 6'h0f;
	localparam logic [5:0] CVR_IDX_VSYNC_START = 6'h10;
	localparam logic [5:0] CVR_IDX_VSYNC_END = 6'h11;
	localparam logic [5:0] CVR_IDX_VDISP_END = 6'h12;
	localparam logic [5:0] CVR_IDX_ROW_PITCH = 6'h13;
	localparam logic [5:0] CVR_IDX_UNDERLINE = 6'h14;
	localparam logic [5:0] CVR_IDX_VBLANK_START = 6'h15;
	localparam logic [5:0] CVR_IDX_VBLANK_END = 6'h16;
	localparam logic [5:0] CVR_IDX_MODE_CTRL = 6'h17;
	localparam logic [5:0] CVR_IDX_HGROUP_LAST = 6'h07;
	localparam logic [5:0] CVR_IDX_OVERFLOW = 6'h07;
	// Field positions
	localparam int CVR_BIT_CURSOR_OFF = 5;
	localparam int CVR_BIT_VINT_CLEAR = 4;
	localparam int CVR_BIT_VINT_ENABLE_N = 5;
	localparam int CVR_BIT_REFRESH_FIVE = 6;
	localparam int CVR_BIT_GROUP0_PROTECT = 7;
	localparam int CVR_BIT_COUNT_BY_FOUR = 5;
	localparam int CVR_BIT_DOUBLE_WORD = 6;
	localparam int CVR_BIT_ROWSCAN_A13_N = 0;
	localparam int CVR_BIT_ROWSCAN_A14_N = 1;
	localparam int CVR_BIT_VCLK_HALF = 2;
	localparam int CVR_BIT_COUNT_BY_TWO = 3;
	localparam int CVR_BIT_WORD_WRAP = 5;
	localparam int CVR_BIT_BYTE_WORD = 6;
	localparam int CVR_BIT_HW_RESET_N = 7;
	localparam int CVR_BIT_LINE_CMP8 = 4;
	// Reset value of every register in this block
	localparam logic [7:0] CVR_REG_RESET = 8'h00;
	// Writable bit masks (reserved bits read zero)
	localparam logic [7:0] CVR_MASK_CUR_START = 8'h3f;
	localparam logic [7:0] CVR_MASK_CUR_END = 8'h7f;
	localparam logic [7:0] CVR_MASK_UNDERLINE = 8'h7f;
	localparam logic [7:0] CVR_MASK_MODE_CTRL = 8'hef;
	// Refresh cycles per scan line
	localparam logic [2:0] CVR_REFRESH_THREE = 3'h3;
	localparam logic [2:0] CVR_REFRESH_FIVE = 3'h5;
	// Legacy emulation address wrap masks
	localparam logic [15:0] CVR_WRAP_16K = 16'h3fff;
	localparam logic [15:0] CVR_WRAP_32K = 16'h7fff;
	localparam logic [15:0] CVR_WRAP_64K = 16'hffff;

	// Addressing modes of the display address counter
	typedef enum logic [1:0] {CVR_ADDR_BYTE, CVR_ADDR_WORD, CVR_ADDR_DWORD} cvr_addr_mode_t;
	// Legacy emulation selector
	typedef enum logic [1:0] {CVR_EMU_NONE, CVR_EMU_16K, CVR_EMU_32K, CVR_EMU_64K} cvr_emu_t;

	// Vertical settings held in neighbouring registers outside this block
	typedef struct packed {
		logic [9:0] vert_total;
		logic [9:0] line_compare;
		logic [4:0] max_scan;
		logic [1:0] vdisp_end_hi;
		logic [1:0] vsync_start_hi;
		logic [1:0] vblank_start_hi;
	} cvr_vert_cfg_t;

	// Video outputs toward the monitor and pixel path
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic vblank;
		logic vdisplay;
		logic cursor;
		logic underline;
	} cvr_video_t;
endpackage

// [test/cvr_crtc_vert_tb.sv]
// Self-checking bench for the vertical CRT timing register block
`timescale 1ns/1ps
module cvr_crtc_vert_tb;
	import cvr_pkg::*;
	logic clk_in = 0;
	logic reset_in = 1;
	logic port_sel_in = 0, port_wr_in = 0, port_rd_in = 0;
	logic [7:0] port_wdata_in = 8'h00;
	logic [7:0] port_rdata_out, hgroup_wmask_out;
	logic port_rvalid_out, hgroup_wr_out, irq_out, vs_done;
	logic rb_sel = 1, ext_prot = 0, char_tick = 0, hline_tick = 0, mono = 0, tick_on = 1;
	cvr_emu_t emu = CVR_EMU_NONE;
	logic [5:0] hgroup_idx_out;
	logic [15:0] mem_addr_out;
	logic [2:0] refresh_cycles_out;
	logic [2:0][9:0] width;
	cvr_video_t video_out;
	// Short frame of 22 lines, line compare out of reach until moved
	cvr_vert_cfg_t cfg = '{vert_total: 10'd20, line_compare: 10'h3ff, max_scan: 5'd1, default: '0};
	logic [7:0] shadow [8'h0a:8'h17];
	logic [7:0] rd_q[$], mask_q[$], vs_q[$], idx_q[$];
	integer seed = 32'h5e02;
	int num_errors = 0, checks_done = 0, tcnt = 0;
	int cur_cnt = 0, ul_cnt = 0, hs_cnt = 0;

	// Clock
	always #2 clk_in = ~clk_in;

	// Line tick every 8 clocks, random character ticks
	always @(negedge clk_in) begin
		tcnt <= (tcnt + 1) % 8;
		hline_tick <= (tcnt == 7);
		char_tick <= tick_on & 1'($random(seed));
	end

	cvr_crtc_vert dut (.clk_in(clk_in), .reset_in(reset_in), .port_sel_in(port_sel_in),
		.port_wr_in(port_wr_in), .port_rd_in(port_rd_in), .port_wdata_in(port_wdata_in),
		.port_rdata_out(port_rdata_out), .port_rvalid_out(port_rvalid_out),
		.hgroup_wr_out(hgroup_wr_out), .hgroup_idx_out(hgroup_idx_out),
		.hgroup_wmask_out(hgroup_wmask_out), .vert_cfg_in(cfg), .vsync_readback_select_in(rb_sel),
		.extension_group0_protect_in(ext_prot), .mono_emulation_in(mono), .emulation_in(emu),
		.character_clock_tick_in(char_tick), .hline_tick_in(hline_tick), .hsync_raw_in(hline_tick),
		.video_out(video_out), .irq_out(irq_out), .mem_addr_out(mem_addr_out),
		.refresh_cycles_out(refresh_cycles_out));

	cvr_monitor_model mon (.clk_in(clk_in), .reset_in(reset_in), .hline_tick_in(hline_tick),
		.video_in(video_out), .vs_done_out(vs_done), .width_out(width));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Oldest note is compared whenever a result appears
	always @(posedge clk_in) begin
		if (port_rvalid_out && rd_q.size() > 0) check(port_rdata_out, rd_q.pop_front());
		if (hgroup_wr_out && mask_q.size() > 0) begin
			check(hgroup_wmask_out, mask_q.pop_front());
			check({2'h0, hgroup_idx_out}, idx_q.pop_front());
		end
		if (video_out.cursor) cur_cnt++;
		if (video_out.underline) ul_cnt++;
		if (video_out.hsync) hs_cnt++;
		if (vs_done && vs_q.size() > 0) check(width[0][7:0], vs_q.pop_front());
	end

	task automatic host(input logic s, input logic w, input logic r, input logic [7:0] d);
		@(negedge clk_in);
		port_sel_in = s;
		port_wr_in = w;
		port_rd_in = r;
		port_wdata_in = d;
	endtask

	// Index first, then data access
	task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
		host(0, 1, 0, i);
		host(1, 1, 0, d);
		host(0, 0, 0, 8'h00);
	endtask

	// Horizontal group write with its expected index and mask
	task automatic hwr(input logic [7:0] i, input logic [7:0] m);
		idx_q.push_back(i);
		mask_q.push_back(m);
		wr_reg(i, 8'h55);
	endtask

	task automatic rd_reg(input logic [7:0] i, input logic [7:0] e);
		host(0, 1, 0, i);
		rd_q.push_back(e);
		host(1, 0, 1, 8'h00);
		host(0, 0, 0, 8'h00);
	endtask

	task automatic lines(input int n);
		repeat (n * 8) @(negedge clk_in);
	endtask

	function automatic logic [7:0] wmask(input int i);
		case (i)
			8'h0a: wmask = CVR_MASK_CUR_START;
			8'h0b: wmask = CVR_MASK_CUR_END;
			8'h14: wmask = CVR_MASK_UNDERLINE;
			8'h17: wmask = CVR_MASK_MODE_CTRL;
			default: wmask = 8'hff;
		endcase
	endfunction

	// Watchdog
	initial begin
		#200000;
		num_errors++;
		summarize();
	end

	// Main sequence
	initial begin
		logic [7:0] d;
		logic bad;
		int c0, u0, h0;
		bad = 0;
		repeat (16) @(negedge clk_in);
		reset_in = 0;
		for (int i = 8'h0a; i <= 8'h17; i++) rd_reg(i[7:0], 8'h00);
		for (int i = 8'h0a; i <= 8'h17; i++) begin
			d = 8'($random(seed));
			shadow[i] = d & wmask(i);
			wr_reg(i[7:0], d);
		end
		for (int i = 8'h0a; i <= 8'h17; i++) rd_reg(i[7:0], shadow[i]);
		rd_q.push_back(8'h17);
		host(0, 0, 1, 8'h00);
		host(0, 0, 0, 8'h00);
		wr_reg(8'h20, 8'hff);
		rd_reg(8'h20, 8'h00);
		rb_sel = 0;
		rd_reg(8'h10, 8'h00);
		rd_reg(8'h11, 8'h00);
		rb_sel = 1;
		// Protection and refresh count
		wr_reg(8'h11, 8'hc0);
		lines(1);
		check({5'h0, refresh_cycles_out}, 8'h05);
		hwr(8'h03, 8'h00);
		hwr(8'h07, 8'h10);
		wr_reg(8'h11, 8'h00);
		lines(1);
		check({5'h0, refresh_cycles_out}, 8'h03);
		hwr(8'h03, 8'hff);
		ext_prot = 1;
		hwr(8'h03, 8'h00);
		ext_prot = 0;
		// Vertical timing over whole frames
		wr_reg(8'h10, 8'h0a);
		wr_reg(8'h11, 8'h1d);
		wr_reg(8'h12, 8'h05);
		wr_reg(8'h15, 8'h08);
		wr_reg(8'h16, 8'h0f);
		wr_reg(8'h17, 8'he3);
		lines(50);
		vs_q.push_back(8'd3);
		lines(50);
		check(width[1][7:0], 8'd7);
		check(width[2][7:0], 8'd6);
		check({7'h0, irq_out}, 8'h01);
		wr_reg(8'h11, 8'h0d);
		lines(1);
		check({7'h0, irq_out}, 8'h00);
		wr_reg(8'h11, 8'h3d);
		lines(50);
		check({7'h0, irq_out}, 8'h00);
		// Cursor, underline, wrapped start address, pitch and line compare
		emu = CVR_EMU_16K;
		cfg.line_compare = 10'd3;
		wr_reg(8'h0a, 8'h00);
		wr_reg(8'h0b, 8'h00);
		wr_reg(8'h0c, 8'hd2);
		wr_reg(8'h0d, 8'h34);
		wr_reg(8'h0e, 8'h12);
		wr_reg(8'h0f, 8'h34);
		wr_reg(8'h13, 8'h10);
		wr_reg(8'h14, 8'h00);
		lines(2);
		c0 = cur_cnt;
		u0 = ul_cnt;
		h0 = hs_cnt;
		lines(50);
		check({5'h0, hs_cnt != h0, cur_cnt != c0, ul_cnt != u0}, 8'h07);
		wr_reg(8'h0a, 8'h20);
		lines(2);
		c0 = cur_cnt;
		lines(50);
		check({7'h0, cur_cnt != c0}, 8'h00);
		wr_reg(8'h0a, 8'h01);
		lines(2);
		c0 = cur_cnt;
		lines(50);
		check({7'h0, cur_cnt != c0}, 8'h00);
		// Without character ticks the counter rests on each row start
		tick_on = 0;
		lines(50);
		mono = 1;
		rd_reg(8'h10, 8'h12);
		rd_reg(8'h11, 8'h54);
		mono = 0;
		@(posedge video_out.vdisplay);
		@(negedge clk_in);
		check(mem_addr_out[15:8], 8'h12);
		check(mem_addr_out[7:0], 8'h34);
		wr_reg(8'h17, 8'ha3);
		@(posedge video_out.vdisplay);
		@(negedge clk_in);
		check(mem_addr_out[15:8], 8'h24);
		check(mem_addr_out[7:0], 8'h68);
		wr_reg(8'h17, 8'ha2);
		@(posedge video_out.vdisplay);
		repeat (2) @(negedge clk_in);
		check(mem_addr_out[15:8], 8'h04);
		tick_on = 1;
		wr_reg(8'h17, 8'he7);
		lines(100);
		vs_q.push_back(8'd6);
		lines(100);
		check({7'h0, vs_q.size() == 0}, 8'h01);
		wr_reg(8'h17, 8'h63);
		lines(1);
		repeat (400) begin
			@(negedge clk_in);
			if (video_out.vsync !== 1'b0 || video_out.hsync !== 1'b0) bad = 1;
		end
		check({7'h0, bad}, 8'h00);
		summarize();
	end
endmodule

// [test/cvr_monitor_model.sv]
// Monitor model that measures vertical pulse widths in scan lines
`timescale 1ns/1ps
module cvr_monitor_model
	import cvr_pkg::*;
(
	// Clock, reset and line events
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic hline_tick_in,
	// Video from the controller
	input wire cvr_pkg::cvr_video_t video_in,
	// Last widths: 0 vsync, 1 vblank, 2 vdisplay
	output logic vs_done_out,
	output logic [2:0][9:0] width_out
);
	logic [2:0] lvl;
	logic [2:0] prev_ff;
	logic [2:0][9:0] cnt_ff;

	// Levels the monitor locks onto
	assign lvl = {video_in.vdisplay, video_in.vblank, video_in.vsync};

	// Count line ticks while each level is high, latch on its fall
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prev_ff <= 3'h0;
			cnt_ff <= '0;
			width_out <= '0;
			vs_done_out <= 1'b0;
		end else begin
			prev_ff <= lvl;
			vs_done_out <= prev_ff[0] & ~lvl[0];
			for (int i = 0; i < 3; i++) begin
				if (prev_ff[i] & ~lvl[i]) begin
					width_out[i] <= cnt_ff[i];
					cnt_ff[i] <= '0;
				end else if (lvl[i] & hline_tick_in) begin
					cnt_ff[i] <= cnt_ff[i] + 10'h001;
				end
			end
		end
	end
endmodule
